// ### rtl/pis_irq_ctrl.sv
// interrupt source block: registers, edge capture, request routing and context save
//
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "pis_defs.svh"
module pis_irq_ctrl #(
  parameter int STACK_DEPTH = 31,
  parameter int PC_WIDTH    = 21
) (
  // clock and reset
  input  wire logic                core_clk,
  input  wire logic                rst_n,
  // apb slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  input  wire logic [3:0]          pstrb,
  output logic                     pready,
  output logic      [31:0]         prdata,
  output logic                     pslverr,
  // pins from outside
  input  wire logic [3:0]          extLinePin,
  input  wire logic [3:0]          portBHighPin,
  // same-clock sources
  input  wire logic [15:0]         timerZeroCount,
  input  wire logic [7:0]          periphTwoPend,
  input  wire logic [7:0]          periphThreePend,
  input  wire logic                displayTypeBActive,
  input  wire logic                watchdogExpiryIn,
  input  wire logic                sleepEntryIn,
  // core requests
  output logic                     irqHigh,
  output logic                     irqLow,
  output logic                     wakeReq,
  // context save
  input  wire logic                entryAck,
  input  wire logic                returnAck,
  input  wire logic                fastReturn,
  input  wire logic [PC_WIDTH-1:0] returnPcIn,
  input  wire pis_pkg::pis_byte_t  workingIn,
  input  wire pis_pkg::pis_byte_t  statusIn,
  input  wire pis_pkg::pis_byte_t  bankSelectIn,
  output logic      [PC_WIDTH-1:0] restorePc,
  output logic                     restoreValid,
  output logic                     restoreFast,
  output pis_pkg::pis_byte_t       shadowWorking,
  output pis_pkg::pis_byte_t       shadowStatus,
  output pis_pkg::pis_byte_t       shadowBankSelect,
  output logic                     stackOverflow
);
  localparam int SP_W = $clog2(STACK_DEPTH + 1);

  if (STACK_DEPTH < 1 || STACK_DEPTH > 255 || PC_WIDTH < 1) begin : g_chk
    $error("pis_irq_ctrl stack depth or address width out of range");
  end

  // ****************************************
  // mapped addresses
  // ****************************************
  function automatic logic pis_mapped(input logic [11:0] a);
    return a == `PIS_OFS_PRIO2 || a == `PIS_OFS_PRIO3 || a == `PIS_OFS_RCTL ||
           a == `PIS_OFS_CTL1 || a == `PIS_OFS_CTL2 || a == `PIS_OFS_CTL3 ||
           a == `PIS_OFS_TMR0;
  endfunction

  // ****************************************
  // declarations
  // ****************************************
  pis_pkg::pis_byte_t prio2_q, prio2_d, prio3_q, prio3_d, rctl_q, rctl_d;
  pis_pkg::pis_byte_t ctl1_q, ctl1_d, ctl2_q, ctl2_d, ctl3_q, ctl3_d, rdVal;
  logic               tmr16_q, tmr16_d;
  logic [15:0]        prevCount_q, prevCount_d;
  logic               pready_q, pready_d, pslverr_q, pslverr_d;
  logic [31:0]        prdata_q, prdata_d;
  logic               setup, complete, hit, wrEn;
  logic [3:0]         extRise, extFall, pbRise, pbFall, extPol, extEvt;
  logic [3:0]         extFl, extEn, extPend, extLvl;
  logic               pbEvt, t0Wrap, t0Pend, pbPend, lvlMode, global_irq_enable, peripheral_irq_enable;
  pis_pkg::pis_byte_t p2Pend, p3Pend;
  logic               hiAny, loAny, coreAny, perAny;
  logic               irqHigh_q, irqHigh_d, irqLow_q, irqLow_d, wake_q, wake_d;
  logic [SP_W-1:0]    sp_q, sp_d;
  pis_pkg::pis_byte_t shW_q, shW_d, shS_q, shS_d, shB_q, shB_d;
  logic               rValid_q, rValid_d, rFast_q, rFast_d, ovf_q, ovf_d;
  logic               doPush, doPop;
  pis_pkg::pis_stk_op_t stkOp;

  // ****************************************
  // pin capture
  // ****************************************
  pis_pin_sync #(.N(4)) u_extSync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .pinIn    (extLinePin),
    .rise_q   (extRise),
    .fall_q   (extFall)
  );

  pis_pin_sync #(.N(4)) u_pbSync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .pinIn    (portBHighPin),
    .rise_q   (pbRise),
    .fall_q   (pbFall)
  );

  // ****************************************
  // apb slave, zero wait states
  // ****************************************
  always_comb begin
    setup     = psel && !penable;
    complete  = psel && penable && pready_q;
    hit       = pis_mapped(paddr);
    wrEn      = complete && pwrite && hit && pstrb[0];
    pready_d  = setup;
    pslverr_d = setup && !hit;
    case (paddr)
      `PIS_OFS_PRIO2: rdVal = prio2_q & `PIS_PRIO2_MASK;
      `PIS_OFS_PRIO3: rdVal = (prio3_q & `PIS_PRIO3_WMASK) | `PIS_PRIO3_ROONE;
      `PIS_OFS_RCTL: begin
        rdVal = rctl_q & `PIS_RCTL_WMASK;
        rdVal[`PIS_RCTL_WDT] = watchdogExpiryIn;
        rdVal[`PIS_RCTL_SLP] = sleepEntryIn;
      end
      `PIS_OFS_CTL1: rdVal = ctl1_q;
      `PIS_OFS_CTL2: rdVal = ctl2_q;
      `PIS_OFS_CTL3: rdVal = ctl3_q;
      `PIS_OFS_TMR0: rdVal = {7'h00, tmr16_q};
      default:       rdVal = 8'h00;
    endcase
    prdata_d = (setup && !pwrite) ? {24'h00_0000, rdVal} : prdata_q;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q  <= prdata_d;
    end
  end

  // ****************************************
  // events and registers
  // ****************************************
  always_comb begin
    extPol = {ctl2_q[3], ctl2_q[4], ctl2_q[5], ctl2_q[6]};
    extEvt = (extPol & extRise) | (~extPol & extFall);
    pbEvt  = |(pbRise | pbFall);
    t0Wrap = tmr16_q ? (prevCount_q == `PIS_T0_MAX16 && timerZeroCount == 16'h0000)
                     : (prevCount_q[7:0] == `PIS_T0_MAX8 && timerZeroCount[7:0] == 8'h00);
    prio2_d     = prio2_q;
    prio3_d     = prio3_q;
    rctl_d      = rctl_q;
    ctl1_d      = ctl1_q;
    ctl2_d      = ctl2_q;
    ctl3_d      = ctl3_q;
    tmr16_d     = tmr16_q;
    prevCount_d = timerZeroCount;
    if (wrEn) begin
      case (paddr)
        `PIS_OFS_PRIO2: prio2_d = pwdata[7:0] & `PIS_PRIO2_MASK;
        `PIS_OFS_PRIO3: prio3_d = pwdata[7:0] & `PIS_PRIO3_WMASK;
        `PIS_OFS_RCTL:  rctl_d  = pwdata[7:0] & `PIS_RCTL_WMASK;
        `PIS_OFS_CTL1:  ctl1_d  = pwdata[7:0];
        `PIS_OFS_CTL2:  ctl2_d  = pwdata[7:0] & `PIS_CTL2_WMASK;
        `PIS_OFS_CTL3:  ctl3_d  = pwdata[7:0];
        `PIS_OFS_TMR0:  tmr16_d = pwdata[0];
        default: begin
        end
      endcase
    end
    // hardware sets after the write so an event beats a clear in the same cycle
    ctl1_d[`PIS_C1_E0FL] = ctl1_d[`PIS_C1_E0FL] | extEvt[0];
    ctl3_d[2:0]          = ctl3_d[2:0] | extEvt[3:1];
    ctl1_d[`PIS_C1_T0FL] = ctl1_d[`PIS_C1_T0FL] | t0Wrap;
    ctl1_d[`PIS_C1_PBFL] = ctl1_d[`PIS_C1_PBFL] | pbEvt;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      prio2_q     <= `PIS_PRIO2_RST;
      prio3_q     <= `PIS_PRIO3_RST;
      rctl_q      <= `PIS_RCTL_RST;
      ctl1_q      <= `PIS_CTL1_RST;
      ctl2_q      <= `PIS_CTL2_RST;
      ctl3_q      <= `PIS_CTL3_RST;
      tmr16_q     <= 1'b0;
      prevCount_q <= 16'h0000;
    end else begin
      prio2_q     <= prio2_d;
      prio3_q     <= prio3_d;
      rctl_q      <= rctl_d;
      ctl1_q      <= ctl1_d;
      ctl2_q      <= ctl2_d;
      ctl3_q      <= ctl3_d;
      tmr16_q     <= tmr16_d;
      prevCount_q <= prevCount_d;
    end
  end

  // ****************************************
  // request routing
  // ****************************************
  always_comb begin
    lvlMode = rctl_q[`PIS_RCTL_LVL];
    global_irq_enable     = ctl1_q[`PIS_C1_GIE];
    peripheral_irq_enable    = ctl1_q[`PIS_C1_PERIPHERAL_IRQ_ENABLE];
    extFl   = {ctl3_q[2:0], ctl1_q[`PIS_C1_E0FL]};
    extEn   = {ctl3_q[5:3], ctl1_q[`PIS_C1_E0EN]};
    extPend = extFl & extEn;
    extLvl  = {ctl2_q[`PIS_C2_E3LV], ctl3_q[`PIS_C3_E2LV], ctl3_q[`PIS_C3_E1LV], 1'b1};
    t0Pend  = ctl1_q[`PIS_C1_T0FL] && ctl1_q[`PIS_C1_T0EN];
    pbPend  = ctl1_q[`PIS_C1_PBFL] && ctl1_q[`PIS_C1_PBEN];
    p2Pend  = periphTwoPend & `PIS_PRIO2_MASK;
    p3Pend  = periphThreePend & (`PIS_PRIO3_WMASK | `PIS_PRIO3_ROONE);
    // display level is meaningless outside type-B non-static drive
    p3Pend[`PIS_PRIO3_DISP] = p3Pend[`PIS_PRIO3_DISP] && displayTypeBActive;
    coreAny = |extPend || t0Pend || pbPend;
    perAny  = |p2Pend || |p3Pend;
    hiAny   = |(extPend & extLvl) || (t0Pend && ctl2_q[`PIS_C2_T0LV]) ||
              (pbPend && ctl2_q[`PIS_C2_PBLV]) || |(p2Pend & prio2_q) ||
              |(p3Pend & (prio3_q | `PIS_PRIO3_ROONE));
    loAny   = |(extPend & ~extLvl) || (t0Pend && !ctl2_q[`PIS_C2_T0LV]) ||
              (pbPend && !ctl2_q[`PIS_C2_PBLV]) || |(p2Pend & ~prio2_q) ||
              |(p3Pend & ~prio3_q & ~`PIS_PRIO3_ROONE) ||
              |(p3Pend & `PIS_PRIO3_ROONE & 8'h00);
    if (lvlMode) begin
      irqHigh_d = global_irq_enable && hiAny;
      irqLow_d  = global_irq_enable && peripheral_irq_enable && loAny;
    end else begin
      irqHigh_d = global_irq_enable && (coreAny || (peripheral_irq_enable && perAny));
      irqLow_d  = 1'b0;
    end
    wake_d = |extPend;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      irqHigh_q <= 1'b0;
      irqLow_q  <= 1'b0;
      wake_q    <= 1'b0;
    end else begin
      irqHigh_q <= irqHigh_d;
      irqLow_q  <= irqLow_d;
      wake_q    <= wake_d;
    end
  end

  // ****************************************
  // context save on entry, restore on return
  // ****************************************
  pis_stack_mem #(.WIDTH(PC_WIDTH), .DEPTH(STACK_DEPTH), .ADDR_W(SP_W)) u_stack (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .wrEn     (doPush),
    .wrAddr   (sp_q),
    .wrData   (returnPcIn),
    .rdEn     (doPop),
    .rdAddr   (sp_q - 1'b1),
    .rdData_q (restorePc)
  );

  // entry wins if both strobes arrive together; a full stack drops the push
  always_comb begin
    doPush = entryAck && (sp_q < SP_W'(STACK_DEPTH));
    doPop  = !entryAck && returnAck && (sp_q != '0);
    stkOp  = doPush ? pis_pkg::PIS_STK_PUSH : doPop ? pis_pkg::PIS_STK_POP
                                                    : pis_pkg::PIS_STK_IDLE;
    sp_d     = sp_q;
    shW_d    = shW_q;
    shS_d    = shS_q;
    shB_d    = shB_q;
    ovf_d    = ovf_q || (entryAck && !doPush);
    rValid_d = 1'b0;
    rFast_d  = 1'b0;
    case (stkOp)
      pis_pkg::PIS_STK_PUSH: begin
        sp_d  = sp_q + 1'b1;
        shW_d = workingIn;
        shS_d = statusIn;
        shB_d = bankSelectIn;
      end
      pis_pkg::PIS_STK_POP: begin
        sp_d     = sp_q - 1'b1;
        rValid_d = 1'b1;
        rFast_d  = fastReturn;
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sp_q     <= '0;
      shW_q    <= 8'h00;
      shS_q    <= 8'h00;
      shB_q    <= 8'h00;
      rValid_q <= 1'b0;
      rFast_q  <= 1'b0;
      ovf_q    <= 1'b0;
    end else begin
      sp_q     <= sp_d;
      shW_q    <= shW_d;
      shS_q    <= shS_d;
      shB_q    <= shB_d;
      rValid_q <= rValid_d;
      rFast_q  <= rFast_d;
      ovf_q    <= ovf_d;
    end
  end

  assign pready           = pready_q;
  assign pslverr          = pslverr_q;
  assign prdata           = prdata_q;
  assign irqHigh          = irqHigh_q;
  assign irqLow           = irqLow_q;
  assign wakeReq          = wake_q;
  assign restoreValid     = rValid_q;
  assign restoreFast      = rFast_q;
  assign shadowWorking    = shW_q;
  assign shadowStatus     = shS_q;
  assign shadowBankSelect = shB_q;
  assign stackOverflow    = ovf_q;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  property p_prio2Zero;
    setup && !pwrite && paddr == `PIS_OFS_PRIO2 |=> prdata_q[5:4] == 2'b00 && !prdata_q[0];
  endproperty
  a_prio2Zero: assert property (p_prio2Zero) else $error("reserved bits read nonzero");

  property p_prio3Ones;
    setup && !pwrite && paddr == `PIS_OFS_PRIO3 |=> prdata_q[5:4] == 2'b11 && !prdata_q[7];
  endproperty
  a_prio3Ones: assert property (p_prio3Ones) else $error("serial levels not one");

  property p_line0Rise;
    ctl2_q[6] && extRise[0] && !ctl1_q[`PIS_C1_E0FL] |=> ctl1_q[`PIS_C1_E0FL];
  endproperty
  a_line0Rise: assert property (p_line0Rise) else $error("rising edge lost");

  property p_flagHolds;
    ctl3_q[0] && !(wrEn && paddr == `PIS_OFS_CTL3) |=> ctl3_q[0];
  endproperty
  a_flagHolds: assert property (p_flagHolds) else $error("line flag cleared by hardware");

  property p_line0High;
    lvlMode && global_irq_enable && extPend[0] |=> irqHigh_q;
  endproperty
  a_line0High: assert property (p_line0High) else $error("line zero not high");

  property p_singleLevel;
    !lvlMode |=> !irqLow_q;
  endproperty
  a_singleLevel: assert property (p_singleLevel) else $error("low request in single mode");

  property p_periphGate;
    !lvlMode && !peripheral_irq_enable && !coreAny |=> !irqHigh_q;
  endproperty
  a_periphGate: assert property (p_periphGate) else $error("peripheral passed without enable");

  property p_noGlobal;
    !global_irq_enable |=> !irqHigh_q && !irqLow_q;
  endproperty
  a_noGlobal: assert property (p_noGlobal) else $error("request without global enable");

  property p_wrap8;
    !tmr16_q && prevCount_q[7:0] == 8'hFF && timerZeroCount[7:0] == 8'h00 |=> ctl1_q[2];
  endproperty
  a_wrap8: assert property (p_wrap8) else $error("timer wrap missed");

  property p_wake;
    |extPend |=> wakeReq;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on enabled line");

  property p_push;
    doPush |=> sp_q == $past(sp_q) + 1'b1 && shadowWorking == $past(workingIn);
  endproperty
  a_push: assert property (p_push) else $error("context not saved");
endmodule
`default_nettype wire

// ### rtl/pis_defs.svh
// register offsets, field positions and reset values of the interrupt source block
`ifndef PIS_DEFS_SVH
`define PIS_DEFS_SVH

// ****************************************
// register offsets
// ****************************************
`define PIS_OFS_PRIO2    12'h000
`define PIS_OFS_PRIO3    12'h004
`define PIS_OFS_RCTL     12'h008
`define PIS_OFS_CTL1     12'h00C
`define PIS_OFS_CTL2     12'h010
`define PIS_OFS_CTL3     12'h014
`define PIS_OFS_TMR0     12'h018

// ****************************************
// masks and reset values
// ****************************************
`define PIS_PRIO2_MASK   8'hCE
`define PIS_PRIO2_RST    8'hCE
`define PIS_PRIO3_WMASK  8'h46
`define PIS_PRIO3_ROONE  8'h30
`define PIS_PRIO3_RST    8'h46
`define PIS_RCTL_WMASK   8'hB3
`define PIS_RCTL_RST     8'h30
`define PIS_CTL1_RST     8'h00
`define PIS_CTL2_RST     8'h7F
`define PIS_CTL2_WMASK   8'h7F
`define PIS_CTL3_RST     8'hC0

// ****************************************
// field positions
// ****************************************
`define PIS_RCTL_LVL     7
`define PIS_RCTL_WDT     3
`define PIS_RCTL_SLP     2
`define PIS_C1_GIE       7
`define PIS_C1_PERIPHERAL_IRQ_ENABLE      6
`define PIS_C1_T0EN      5
`define PIS_C1_E0EN      4
`define PIS_C1_PBEN      3
`define PIS_C1_T0FL      2
`define PIS_C1_E0FL      1
`define PIS_C1_PBFL      0
`define PIS_C2_T0LV      2
`define PIS_C2_E3LV      1
`define PIS_C2_PBLV      0
`define PIS_C3_E2LV      7
`define PIS_C3_E1LV      6
`define PIS_PRIO3_DISP   6

// ****************************************
// timer-zero wrap values
// ****************************************
`define PIS_T0_MAX8      8'hFF
`define PIS_T0_MAX16     16'hFFFF

`endif

// ### rtl/pis_pkg.sv
// shared types of the interrupt source block
package pis_pkg;
  typedef logic [7:0] pis_byte_t;
  typedef enum logic [1:0] {PIS_STK_IDLE, PIS_STK_PUSH, PIS_STK_POP} pis_stk_op_t;
endpackage

// ### rtl/pis_pin_sync.sv
// three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps
`default_nettype none
module pis_pin_sync #(
  parameter int N = 4
) (
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  // pins and events
  input  wire logic [N-1:0] pinIn,
  output logic      [N-1:0] rise_q,
  output logic      [N-1:0] fall_q
);
  logic [N-1:0] s1_q, s2_q, s3_q, stable_q, stable_d, rise_d, fall_d;
  logic         primed_q, primed_d;

  if (N < 1) begin : g_chk
    $error("pis_pin_sync needs at least one pin");
  end

  // the first agreed value after reset primes the filter without an event
  always_comb begin
    primed_d = 1'b1;
    for (int i = 0; i < N; i++) begin
      stable_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : stable_q[i];
    end
    rise_d = primed_q ? (stable_d & ~stable_q) : '0;
    fall_d = primed_q ? (~stable_d & stable_q) : '0;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      // stages load during reset so a pin idling high gives no false edge
      s1_q     <= pinIn;
      s2_q     <= s1_q;
      s3_q     <= s2_q;
      stable_q <= s3_q;
      primed_q <= 1'b0;
      rise_q   <= '0;
      fall_q   <= '0;
    end else begin
      s1_q     <= pinIn;
      s2_q     <= s1_q;
      s3_q     <= s2_q;
      stable_q <= stable_d;
      primed_q <= primed_d && (s2_q == s3_q) ? 1'b1 : primed_q;
      rise_q   <= rise_d;
      fall_q   <= fall_d;
    end
  end
endmodule
`default_nettype wire

// ### rtl/pis_stack_mem.sv
// return address stack memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module pis_stack_mem #(
  parameter int WIDTH  = 21,
  parameter int DEPTH  = 31,
  parameter int ADDR_W = 5
) (
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  // write side
  input  wire logic              wrEn,
  input  wire logic [ADDR_W-1:0] wrAddr,
  input  wire logic [WIDTH-1:0]  wrData,
  // read side
  input  wire logic              rdEn,
  input  wire logic [ADDR_W-1:0] rdAddr,
  output logic      [WIDTH-1:0]  rdData_q
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] rdData_d;

  if (DEPTH < 1 || DEPTH > (1 << ADDR_W)) begin : g_chk
    $error("pis_stack_mem depth does not fit the address width");
  end

  always_comb begin
    rdData_d = rdEn ? mem[rdAddr] : rdData_q;
  end

  // array has no reset: contents are only read after a push
  always_ff @(posedge core_clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    if (!rst_n) begin
      rdData_q <= '0;
    end else begin
      rdData_q <= rdData_d;
    end
  end
endmodule
`default_nettype wire

// ### tb/pis_core_model.sv
// core-side partner: handler entry and return pulses carrying context
`timescale 1ns/1ps
`default_nettype none
module pis_core_model (
  // clock and commands
  input  wire logic          core_clk,
  input  wire logic          doEntry,
  input  wire logic          doReturn,
  // toward the block
  output logic               entryAck   = 1'b0,
  output logic               returnAck  = 1'b0,
  output logic               fastReturn = 1'b0,
  output logic [20:0]        returnPc   = 21'h0_0000,
  output pis_pkg::pis_byte_t working    = 8'h00
);
  // context is only valid with entryAck, so it wanders between entries
  always @(posedge core_clk) begin
    entryAck   <= doEntry;
    returnAck  <= doReturn;
    fastReturn <= doReturn;
    returnPc   <= doEntry ? 21'h0_1A5C : ~returnPc;
    working    <= doEntry ? 8'h3C : ~working;
  end
endmodule
`default_nettype wire

// ### tb/testbench.sv
// register, pin and context tests of the interrupt source block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin miscompares++; \
  $display("Error %s expected %h seen %h", nm, ex, gt); end end
module testbench;
  logic core_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, rd;
  logic [3:0]  ext = 4'h0, pb = 4'h0;
  logic [15:0] tmr = 16'h0000;
  logic [7:0]  pend2 = 8'h00;
  logic pready, pslverr, irqHigh, irqLow, wakeReq, eAck, rAck, fRet, rValid, rFast, err;
  logic doEntry = 0, doReturn = 0;
  logic [20:0] pc, rPc;
  logic ovf;
  pis_pkg::pis_byte_t wk, shW, shS, shB;
  logic [31:0] prdata;
  int miscompares = 0, total_checks = 0, cyc = 0;
  always #2.5 core_clk = ~core_clk;
  pis_core_model core (.core_clk(core_clk), .doEntry(doEntry), .doReturn(doReturn),
    .entryAck(eAck), .returnAck(rAck), .fastReturn(fRet), .returnPc(pc), .working(wk));
  pis_irq_ctrl uut (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'h1), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .extLinePin(ext), .portBHighPin(pb),
    .timerZeroCount(tmr), .periphTwoPend(pend2), .periphThreePend(8'h00),
    .displayTypeBActive(1'b1), .watchdogExpiryIn(1'b1), .sleepEntryIn(1'b0),
    .irqHigh(irqHigh), .irqLow(irqLow), .wakeReq(wakeReq), .entryAck(eAck),
    .returnAck(rAck), .fastReturn(fRet), .returnPcIn(pc), .workingIn(wk), .statusIn(wk),
    .bankSelectIn(wk), .restorePc(rPc), .restoreValid(rValid), .restoreFast(rFast),
    .shadowWorking(shW), .shadowStatus(shS), .shadowBankSelect(shB), .stackOverflow(ovf));
  task automatic complete_run();
    if (miscompares == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // one apb transfer; waits for pready, then releases and idles a cycle
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= {24'h00_0000, d};
    @(posedge core_clk);
    penable <= 1;
    do begin @(posedge core_clk); end while (pready !== 1'b1);
    rd = prdata; err = pslverr;
    psel <= 0; penable <= 0;
    @(posedge core_clk);
  endtask
  task automatic cyc_wait(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  always @(posedge core_clk) if (++cyc > 3000) begin miscompares++; complete_run(); end
  initial begin
    cyc_wait(10);
    rst_n <= 1;
    cyc_wait(1);
    // ****************************************
    // registers
    // ****************************************
    apb(0, 12'h000, 8'h00); `CHK("prio2 reset", 32'h0000_00CE, rd)
    apb(0, 12'h004, 8'h00); `CHK("prio3 reset", 32'h0000_0076, rd)
    apb(0, 12'h008, 8'h00); `CHK("rctl reset", 32'h0000_0038, rd)
    apb(1, 12'h000, 8'hFF); apb(0, 12'h000, 8'h00); `CHK("prio2", 32'h0000_00CE, rd)
    apb(1, 12'h000, 8'h00); apb(0, 12'h000, 8'h00); `CHK("prio2 lo", 32'h0000_0000, rd)
    apb(1, 12'h004, 8'h00); apb(0, 12'h004, 8'h00); `CHK("prio3 lo", 32'h0000_0030, rd)
    apb(1, 12'h008, 8'hFF); apb(0, 12'h008, 8'h00); `CHK("rctl", 32'h0000_00BB, rd)
    apb(1, 12'h008, 8'h00); apb(0, 12'h100, 8'h00); `CHK("unmapped", 1'b1, err)
    // ****************************************
    // pins, timer and peripheral routing
    // ****************************************
    apb(1, 12'h00C, 8'h90); ext[0] <= 1; cyc_wait(8);
    `CHK("line0 irq", 1'b1, irqHigh)
    `CHK("line0 wake", 1'b1, wakeReq)
    apb(1, 12'h00C, 8'h82); apb(0, 12'h00C, 8'h00); `CHK("flag kept", 32'h0000_0082, rd)
    `CHK("masked", 1'b0, irqHigh)
    apb(1, 12'h00C, 8'h90); ext[0] <= 0; cyc_wait(8);
    `CHK("wrong edge", 1'b0, irqHigh)
    tmr <= 16'h00FF; cyc_wait(1); tmr <= 16'h0000; pb[2] <= 1; cyc_wait(8);
    apb(0, 12'h00C, 8'h00); `CHK("timer pb flags", 32'h0000_0095, rd)
    apb(1, 12'h00C, 8'hC0); pend2 <= 8'h80; cyc_wait(3);
    `CHK("single lvl", 1'b1, irqHigh)
    apb(1, 12'h008, 8'h80); cyc_wait(3);
    `CHK("low lvl", 1'b1, irqLow)
    pend2 <= 8'h00; apb(1, 12'h014, 8'h88); apb(1, 12'h00C, 8'hD0);
    ext[1:0] <= 2'b11; cyc_wait(8);
    `CHK("line0 lvl", 1'b1, irqHigh)
    `CHK("line1 lvl", 1'b1, irqLow)
    `CHK("lvl wake", 1'b1, wakeReq)
    apb(0, 12'h014, 8'h00); `CHK("line1 flag", 32'h0000_0089, rd)
    apb(1, 12'h018, 8'h01); tmr <= 16'h12FF; cyc_wait(1); tmr <= 16'h1300; cyc_wait(2);
    apb(0, 12'h00C, 8'h00); `CHK("t16 no wrap", 32'h0000_00D2, rd)
    tmr <= 16'hFFFF; cyc_wait(1); tmr <= 16'h0000; cyc_wait(2);
    apb(0, 12'h00C, 8'h00); `CHK("t16 wrap", 32'h0000_00D6, rd)
    // ****************************************
    // context save
    // ****************************************
    doEntry <= 1; cyc_wait(1); doEntry <= 0; cyc_wait(4);
    `CHK("shadow", 8'h3C, shW)
    `CHK("shadow status", 8'h3C, shS)
    `CHK("shadow bank", 8'h3C, shB)
    `CHK("no overflow", 1'b0, ovf)
    doReturn <= 1; cyc_wait(1); doReturn <= 0;
    repeat (10) begin @(posedge core_clk); if (rValid === 1'b1) break; end
    `CHK("restore pc", 21'h0_1A5C, rPc)
    `CHK("restore fast", 1'b1, rFast)
    complete_run();
  end
endmodule
`default_nettype wire
